// ### common/osct_consts.svh
// Offsets, field positions, reset values and timing counts of the oscillator control block
`ifndef OSCT_CONSTS_SVH
`define OSCT_CONSTS_SVH

// Register byte addresses on the special-function bus
`define OSCT_ADDR_W 20
`define OSCT_ADDR_TRIM 20'hF00A0
`define OSCT_ADDR_FREQ 20'hF00A8

// Frequency-select field
`define OSCT_FREQ_LSB 0
`define OSCT_FREQ_MSB 2
`define OSCT_CODE_16M 3'h1
`define OSCT_CODE_8M 3'h2
`define OSCT_CODE_4M 3'h3
`define OSCT_CODE_2M 3'h4
`define OSCT_CODE_1M 3'h5
`define OSCT_CODE_SAFE 3'h1

// Trim field
`define OSCT_TRIM_LSB 0
`define OSCT_TRIM_MSB 5
`define OSCT_TRIM_W 6

// Reset values before the boot load
`define OSCT_FREQ_RST 3'h1
`define OSCT_TRIM_RST 6'h00

// Switch-over transition, in core clock cycles
`define OSCT_OLD_CYCLES 3
`define OSCT_WAIT_CYCLES 3
`define OSCT_CNT_W 2

`endif

// ### common/osct_pkg.sv
// Types of the oscillator select and trim block
package osct_pkg;

    typedef enum logic [1:0] {
        OSCT_PIN_PORT,
        OSCT_PIN_CRYSTAL,
        OSCT_PIN_EXT_CLK,
        OSCT_PIN_RESERVED
    } osct_pin_mode_t;

    typedef enum logic [1:0] {
        OSCT_XF_IDLE,
        OSCT_XF_OLD,
        OSCT_XF_WAIT
    } osct_xfer_t;

endpackage

// ### hdl/osct_top.sv
// Oscillator frequency select, trim and oscillator pin-mode control
`timescale 1ns/1ps
`include "osct_consts.svh"

module osct_top
    import osct_pkg::*;
(
    input wire logic sys_clk_in, // Core clock
    input wire logic rst_in, // Async reset, active high
    input wire logic [`OSCT_ADDR_W-1:0] sfr_addr_in, // Register byte address
    input wire logic sfr_wr_in, // Write strobe
    input wire logic sfr_rd_in, // Read strobe
    input wire logic [7:0] sfr_wdata_in, // Write data
    output logic [7:0] sfr_rdata_out, // Read data, valid after read
    input wire logic [2:0] boot_freq_code_in, // Option byte code bits
    input wire logic [`OSCT_TRIM_W-1:0] factory_trim_in, // Shipment trim
    input wire logic core_periph_clk_is_hs_in, // Core clock taken from fast osc
    input wire logic main_ext_clk_sel_in, // Main pin pair, upper bit
    input wire logic main_osc_pin_mode_in, // Main pin pair, lower bit
    input wire logic sub_ext_clk_sel_in, // Sub pin pair, upper bit
    input wire logic sub_osc_pin_mode_in, // Sub pin pair, lower bit
    input wire logic sub_drive_mode_b1_in, // Sub drive field, upper bit
    input wire logic sub_drive_mode_b0_in, // Sub drive field, lower bit
    input wire logic hs_osc_halt_in, // Fast osc halt bit
    input wire logic wdt_running_in, // Watchdog operating
    input wire logic lowspeed_timer_clk_sel_in, // Timer clock select bit
    output logic [2:0] hs_freq_code_out, // Code in effect at the osc
    output logic [2:0] hs_div_log2_out, // 16 MHz divided by 2**n
    output logic [`OSCT_TRIM_W-1:0] hs_trim_out, // Trim to the osc
    output logic core_periph_clk_wait_out, // Core clock held in wait
    output logic xfer_busy_out, // Switch-over in progress
    output logic hs_osc_run_out, // Fast osc enable
    output logic ls_osc_run_out, // Slow osc enable
    output logic ls_to_wdt_out, // Slow clock gated to watchdog
    output logic ls_to_timer_out, // Slow clock picked for timers
    output osct_pin_mode_t main_pin_mode_out, // Main osc pin mode
    output logic main_pins_port_out, // Main pins are input ports
    output osct_pin_mode_t sub_pin_mode_out, // Sub osc pin mode
    output logic sub_pins_port_out, // Sub pins are input ports
    output logic sub_ulp_mode_out // Sub osc ultra-low power
);

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic code_legal(input logic [2:0] code);
        code_legal = (code >= `OSCT_CODE_16M) && (code <= `OSCT_CODE_1M);
    endfunction

    function automatic osct_pin_mode_t pin_mode(input logic ext, input logic osc);
        case ({ext, osc})
            2'h1: pin_mode = OSCT_PIN_CRYSTAL;
            2'h3: pin_mode = OSCT_PIN_EXT_CLK;
            2'h0: pin_mode = OSCT_PIN_PORT;
            default: pin_mode = OSCT_PIN_RESERVED;
        endcase
    endfunction

    function automatic logic [2:0] code_to_log2(input logic [2:0] code);
        code_to_log2 = code - 3'h1;
    endfunction

    function automatic logic addr_hit(input logic [`OSCT_ADDR_W-1:0] addr,
            input logic [`OSCT_ADDR_W-1:0] target);
        addr_hit = (addr == target);
    endfunction

    // ****************************************
    // Register state
    // ****************************************
    logic boot_pend_q;
    logic boot_pend_d;
    logic [2:0] freq_sel_q;
    logic [2:0] freq_sel_d;
    logic [2:0] freq_act_q;
    logic [2:0] freq_act_d;
    logic [`OSCT_TRIM_W-1:0] trim_q;
    logic [`OSCT_TRIM_W-1:0] trim_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    osct_xfer_t xf_q;
    osct_xfer_t xf_d;
    logic [`OSCT_CNT_W-1:0] cnt_q;
    logic [`OSCT_CNT_W-1:0] cnt_d;
    logic hs_run_q;
    logic hs_run_d;
    logic ls_run_q;
    logic ls_run_d;
    logic wr_freq;
    logic wr_trim;
    logic new_code;

    // ****************************************
    // Register access
    // ****************************************
    assign wr_freq = sfr_wr_in && addr_hit(sfr_addr_in, `OSCT_ADDR_FREQ);
    assign wr_trim = sfr_wr_in && addr_hit(sfr_addr_in, `OSCT_ADDR_TRIM);

    always_comb begin
        boot_pend_d = 1'b0;
        freq_sel_d = freq_sel_q;
        trim_d = trim_q;
        new_code = 1'b0;
        if (boot_pend_q) begin
            // Straps taken on the first edge after release
            if (code_legal(boot_freq_code_in)) begin
                freq_sel_d = boot_freq_code_in;
            end else begin
                freq_sel_d = `OSCT_CODE_SAFE;
            end
            trim_d = factory_trim_in;
        end else begin
            // Frequency writes while another source drives the core are dropped
            if (wr_freq && core_periph_clk_is_hs_in) begin
                // Only the low three bits are stored
                if (code_legal(sfr_wdata_in[`OSCT_FREQ_MSB:`OSCT_FREQ_LSB])) begin
                    freq_sel_d = sfr_wdata_in[`OSCT_FREQ_MSB:`OSCT_FREQ_LSB];
                    new_code = 1'b1;
                end
            end
            if (wr_trim) begin
                trim_d = sfr_wdata_in[`OSCT_TRIM_MSB:`OSCT_TRIM_LSB];
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            boot_pend_q <= 1'b1;
            freq_sel_q <= `OSCT_FREQ_RST;
            trim_q <= `OSCT_TRIM_RST;
        end else begin
            boot_pend_q <= boot_pend_d;
            freq_sel_q <= freq_sel_d;
            trim_q <= trim_d;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        rdata_d = rdata_q;
        // Data holds until the next read
        if (sfr_rd_in) begin
            case (sfr_addr_in)
                `OSCT_ADDR_FREQ: rdata_d = {5'h00, freq_sel_q};
                `OSCT_ADDR_TRIM: rdata_d = {2'h0, trim_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // Frequency switch-over
    // ****************************************
    always_comb begin
        xf_d = xf_q;
        cnt_d = cnt_q;
        freq_act_d = freq_act_q;
        if (boot_pend_q) begin
            freq_act_d = freq_sel_d;
            xf_d = OSCT_XF_IDLE;
            cnt_d = '0;
        end else if (new_code) begin
            // A fresh code restarts the old-frequency phase
            xf_d = OSCT_XF_OLD;
            cnt_d = '0;
        end else begin
            case (xf_q)
                OSCT_XF_IDLE: begin
                    cnt_d = '0;
                end
                OSCT_XF_OLD: begin
                    if (cnt_q == `OSCT_CNT_W'(`OSCT_OLD_CYCLES - 1)) begin
                        freq_act_d = freq_sel_q;
                        xf_d = OSCT_XF_WAIT;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + `OSCT_CNT_W'(1);
                    end
                end
                OSCT_XF_WAIT: begin
                    if (cnt_q == `OSCT_CNT_W'(`OSCT_WAIT_CYCLES - 1)) begin
                        xf_d = OSCT_XF_IDLE;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + `OSCT_CNT_W'(1);
                    end
                end
                default: begin
                    xf_d = OSCT_XF_IDLE;
                    cnt_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            xf_q <= OSCT_XF_IDLE;
            cnt_q <= '0;
            freq_act_q <= `OSCT_FREQ_RST;
        end else begin
            xf_q <= xf_d;
            cnt_q <= cnt_d;
            freq_act_q <= freq_act_d;
        end
    end

    // ****************************************
    // Oscillator run control
    // ****************************************
    always_comb begin
        hs_run_d = !hs_osc_halt_in;
        ls_run_d = wdt_running_in || lowspeed_timer_clk_sel_in;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hs_run_q <= 1'b0;
            ls_run_q <= 1'b0;
        end else begin
            hs_run_q <= hs_run_d;
            ls_run_q <= ls_run_d;
        end
    end

    // ****************************************
    // Registered output decodes
    // ****************************************
    logic [1:0] pair_ext;
    logic [1:0] pair_osc;
    osct_pin_mode_t mode_d [2];
    osct_pin_mode_t mode_q [2];
    logic port_d [2];
    logic port_q [2];
    logic [2:0] div_d;
    logic [2:0] div_q;
    logic ls_wdt_d;
    logic ls_wdt_q;
    logic ls_tmr_d;
    logic ls_tmr_q;
    logic ulp_d;
    logic ulp_q;

    // Index 0 is the main pair, index 1 the sub pair
    assign pair_ext = {sub_ext_clk_sel_in, main_ext_clk_sel_in};
    assign pair_osc = {sub_osc_pin_mode_in, main_osc_pin_mode_in};

    for (genvar p = 0; p < 2; p++) begin : g_pair
        always_comb begin
            mode_d[p] = pin_mode(pair_ext[p], pair_osc[p]);
            port_d[p] = (mode_d[p] == OSCT_PIN_PORT);
        end

        // Reset shows port mode, the pins' idle use
        always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
                mode_q[p] <= OSCT_PIN_PORT;
                port_q[p] <= 1'b1;
            end else begin
                mode_q[p] <= mode_d[p];
                port_q[p] <= port_d[p];
            end
        end
    end

    // Divider tracks the code register on the same edge
    always_comb begin
        div_d = code_to_log2(freq_act_d);
        ls_wdt_d = ls_run_d && wdt_running_in;
        ls_tmr_d = ls_run_d && lowspeed_timer_clk_sel_in;
        ulp_d = sub_drive_mode_b1_in && !sub_drive_mode_b0_in;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_q <= 3'h0;
            ls_wdt_q <= 1'b0;
            ls_tmr_q <= 1'b0;
            ulp_q <= 1'b0;
        end else begin
            div_q <= div_d;
            ls_wdt_q <= ls_wdt_d;
            ls_tmr_q <= ls_tmr_d;
            ulp_q <= ulp_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign sfr_rdata_out = rdata_q;
    assign hs_freq_code_out = freq_act_q;
    assign hs_div_log2_out = div_q;
    // Trim goes straight to the osc, so its step order is kept
    assign hs_trim_out = trim_q;
    assign core_periph_clk_wait_out = (xf_q == OSCT_XF_WAIT);
    assign xfer_busy_out = (xf_q != OSCT_XF_IDLE);
    assign hs_osc_run_out = hs_run_q;
    assign ls_osc_run_out = ls_run_q;
    // Slow clock has no path to the core clock selector
    assign ls_to_wdt_out = ls_wdt_q;
    assign ls_to_timer_out = ls_tmr_q;
    assign main_pin_mode_out = mode_q[0];
    assign main_pins_port_out = port_q[0];
    assign sub_pin_mode_out = mode_q[1];
    assign sub_pins_port_out = port_q[1];
    assign sub_ulp_mode_out = ulp_q;

endmodule

// ### testbench/osct_top_checker.sv
// Port-level assertions for the oscillator select and trim block
`timescale 1ns/1ps
`include "osct_consts.svh"
module osct_checker
    import osct_pkg::*;
(
    input wire logic sys_clk_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic [`OSCT_ADDR_W-1:0] sfr_addr_in, // Address
    input wire logic sfr_wr_in, // Write
    input wire logic [7:0] sfr_wdata_in, // Data
    input wire logic core_periph_clk_is_hs_in, // Fast source
    input wire logic main_ext_clk_sel_in, // Main upper
    input wire logic main_osc_pin_mode_in, // Main lower
    input wire logic sub_drive_mode_b1_in, // Drive upper
    input wire logic sub_drive_mode_b0_in, // Drive lower
    input wire logic hs_osc_halt_in, // Halt
    input wire logic wdt_running_in, // Watchdog
    input wire logic lowspeed_timer_clk_sel_in, // Timer select
    input wire logic [2:0] hs_freq_code_out, // Code
    input wire logic [2:0] hs_div_log2_out, // Divider
    input wire logic core_periph_clk_wait_out, // Wait
    input wire logic xfer_busy_out, // Busy
    input wire logic hs_osc_run_out, // Fast run
    input wire logic ls_osc_run_out, // Slow run
    input wire logic ls_to_wdt_out, // Slow to watchdog
    input wire logic ls_to_timer_out, // Slow to timers
    input wire osct_pin_mode_t main_pin_mode_out, // Main mode
    input wire logic main_pins_port_out, // Main port
    input wire logic sub_ulp_mode_out // Ultra-low power
);
// ********
// Properties
// ********
logic fw;
logic ok;
assign fw = sfr_wr_in && sfr_addr_in == `OSCT_ADDR_FREQ;
assign ok = sfr_wdata_in[2:0] inside {[3'h1:3'h5]};
default clocking cb @(posedge sys_clk_in);
endclocking
default disable iff (rst_in);
sequence old_run;
    (xfer_busy_out && !core_periph_clk_wait_out) [*3];
endsequence
sequence hold_wait;
    core_periph_clk_wait_out [*3] ##1 (!core_periph_clk_wait_out && !xfer_busy_out);
endsequence
switch_seq_a: assert property ($rose(xfer_busy_out) |-> old_run ##1 hold_wait)
    else $error("switch-over phases wrong");
code_move_a: assert property (
    ($changed(hs_freq_code_out) && !$past(rst_in, 2)) |-> $rose(core_periph_clk_wait_out))
    else $error("code moved outside switch");
accept_a: assert property (
    (fw && ok && core_periph_clk_is_hs_in && !$past(rst_in)) |=> xfer_busy_out)
    else $error("legal write not taken");
refuse_a: assert property (
    (fw && !(ok && core_periph_clk_is_hs_in) && !xfer_busy_out) |=> !xfer_busy_out)
    else $error("refused write started switch");
div_map_a: assert property (
    hs_div_log2_out == hs_freq_code_out - 3'h1 && hs_freq_code_out inside {[3'h1:3'h5]})
    else $error("code or divider wrong");
main_mode_a: assert property (!$past(rst_in) |->
    main_pins_port_out == !$past(main_ext_clk_sel_in || main_osc_pin_mode_in)
    && main_pin_mode_out == ($past(main_osc_pin_mode_in)
    ? ($past(main_ext_clk_sel_in) ? OSCT_PIN_EXT_CLK : OSCT_PIN_CRYSTAL)
    : ($past(main_ext_clk_sel_in) ? OSCT_PIN_RESERVED : OSCT_PIN_PORT)))
    else $error("main pin mode wrong");
sub_ulp_a: assert property (!$past(rst_in) |->
    sub_ulp_mode_out == $past(sub_drive_mode_b1_in && !sub_drive_mode_b0_in))
    else $error("drive mode wrong");
hs_run_a: assert property (
    !$past(rst_in) |-> hs_osc_run_out == !$past(hs_osc_halt_in))
    else $error("fast run wrong");
ls_run_a: assert property (!$past(rst_in) |->
    ls_osc_run_out == $past(wdt_running_in || lowspeed_timer_clk_sel_in))
    else $error("slow run wrong");
ls_route_a: assert property (!$past(rst_in) |->
    ls_to_timer_out == (ls_osc_run_out && $past(lowspeed_timer_clk_sel_in))
    && ls_to_wdt_out == (ls_osc_run_out && $past(wdt_running_in)))
    else $error("slow routing wrong");
endmodule
bind osct_top osct_checker osct_checker_i (.*);

// ### testbench/osct_top_tb_top.sv
// Self-checking bench for the oscillator select and trim block
`timescale 1ns/1ps
`include "osct_consts.svh"
module osct_top_tb_top import osct_pkg::*;;
logic sys_clk_in, rst_in, sfr_wr_in, sfr_rd_in, core_periph_clk_is_hs_in, hs_osc_halt_in, wdt_running_in;
logic main_ext_clk_sel_in, main_osc_pin_mode_in, sub_ext_clk_sel_in, sub_osc_pin_mode_in;
logic sub_drive_mode_b1_in, sub_drive_mode_b0_in, lowspeed_timer_clk_sel_in;
logic [19:0] sfr_addr_in;
logic [7:0] sfr_wdata_in, sfr_rdata_out, pins;
logic [2:0] boot_freq_code_in, hs_freq_code_out, hs_div_log2_out, cur, v;
logic [5:0] factory_trim_in, hs_trim_out;
logic core_periph_clk_wait_out, xfer_busy_out, hs_osc_run_out, ls_osc_run_out, ls_to_wdt_out;
logic ls_to_timer_out, main_pins_port_out, sub_pins_port_out, sub_ulp_mode_out;
osct_pin_mode_t main_pin_mode_out, sub_pin_mode_out;
logic [7:0] bad [3] = '{8'h00, 8'h06, 8'h07};
logic [1:0] pm [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
int n_errors = 0;
int checks_done = 0;
int cyc = 0;
osct_top osct_top_i (.*);
// ********
// Tasks
// ********
function automatic logic [7:0] st();
    return {2'h0, core_periph_clk_wait_out, xfer_busy_out, 1'b0, hs_freq_code_out};
endfunction
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
        n_errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    sfr_wr_in <= 1'b0;
endtask
task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    sfr_rd_in <= 1'b0;
    #1 chk(sfr_rdata_out, exp);
endtask
task automatic rst_seq(input logic [2:0] b, input logic [5:0] t);
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    boot_freq_code_in <= b;
    factory_trim_in <= t;
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
endtask
task automatic close_out;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
        $display("TB: PASS");
    end else begin
        $display("TB: FAIL");
    end
    $finish;
endtask
// ********
// Clock, timeout and tests
// ********
initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
end
always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
        n_errors++;
        close_out();
    end
end
initial begin
    {sfr_wr_in, sfr_rd_in, hs_osc_halt_in, wdt_running_in, lowspeed_timer_clk_sel_in} = '0;
    {main_ext_clk_sel_in, main_osc_pin_mode_in, sub_ext_clk_sel_in, sub_osc_pin_mode_in} = '0;
    {sub_drive_mode_b1_in, sub_drive_mode_b0_in, sfr_addr_in, sfr_wdata_in} = '0;
    {rst_in, core_periph_clk_is_hs_in, boot_freq_code_in, factory_trim_in} = {2'h3, 3'h4, 6'h2A};
    rst_seq(3'h4, 6'h2A);
    rd(`OSCT_ADDR_FREQ, 8'h04);
    rd(`OSCT_ADDR_TRIM, 8'h2A);
    wr(`OSCT_ADDR_TRIM, 8'hFF);
    rd(`OSCT_ADDR_TRIM, 8'h3F);
    chk({2'h0, hs_trim_out}, 8'h3F);
    rd(20'hF00A4, 8'h00);
    cur = 3'h4;
    for (int c = 1; c <= 5; c++) begin
        wr(`OSCT_ADDR_FREQ, 8'hF8 | 8'(c));
        #1 chk(st(), {4'h1, 1'b0, cur});
        repeat (3) @(posedge sys_clk_in);
        #1 chk(st(), {4'h3, 1'b0, 3'(c)});
        chk({5'h00, hs_div_log2_out}, 8'(c - 1));
        repeat (3) @(posedge sys_clk_in);
        #1 chk(st(), {4'h0, 1'b0, 3'(c)});
        cur = 3'(c);
        rd(`OSCT_ADDR_FREQ, {5'h00, cur});
    end
    foreach (bad[k]) begin
        wr(`OSCT_ADDR_FREQ, bad[k]);
        #1 chk(st(), {5'h00, cur});
        rd(`OSCT_ADDR_FREQ, {5'h00, cur});
    end
    @(posedge sys_clk_in);
    core_periph_clk_is_hs_in <= 1'b0;
    wr(`OSCT_ADDR_FREQ, 8'h02);
    #1 chk(st(), {5'h00, cur});
    rd(`OSCT_ADDR_FREQ, {5'h00, cur});
    core_periph_clk_is_hs_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
        @(posedge sys_clk_in);
        {main_ext_clk_sel_in, main_osc_pin_mode_in} <= 2'(i);
        {sub_ext_clk_sel_in, sub_osc_pin_mode_in} <= 2'(i);
        {sub_drive_mode_b1_in, sub_drive_mode_b0_in} <= 2'(i);
        @(posedge sys_clk_in);
        #1 pins = {2'h0, main_pin_mode_out, sub_pin_mode_out, main_pins_port_out, sub_pins_port_out};
        chk(pins, {2'h0, pm[i], pm[i], 1'(i == 0), 1'(i == 0)});
        chk({7'h00, sub_ulp_mode_out}, 8'(i == 2));
    end
    for (int i = 0; i < 8; i++) begin
        v = 3'(i);
        @(posedge sys_clk_in);
        {hs_osc_halt_in, wdt_running_in, lowspeed_timer_clk_sel_in} <= v;
        @(posedge sys_clk_in);
        #1 pins = {3'h0, hs_osc_run_out, ls_osc_run_out, ls_to_wdt_out, ls_to_timer_out, 1'b0};
        chk(pins, {3'h0, ~v[2], v[1] | v[0], v[1], v[0], 1'b0});
    end
    rst_seq(3'h7, 6'h15);
    rd(`OSCT_ADDR_FREQ, 8'h01);
    rd(`OSCT_ADDR_TRIM, 8'h15);
    close_out();
end
endmodule
